/* rtl/tpr_parity.sv */
// Parity generator and checker for one data word
`timescale 1ns/100ps
module tpr_parity #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic [WIDTH-1:0] data_in,
    input wire logic parity_bit_in,
    input wire logic odd_sel_in,
    output logic gen_bit_out,
    output logic error_out
);

    // Generated bit makes the total count odd or even as selected
    assign gen_bit_out = (^data_in) ^ odd_sel_in;

    // Check fails when the total count disagrees with the selected polarity
    assign error_out = ((^data_in) ^ parity_bit_in) != odd_sel_in;

endmodule : tpr_parity

/* rtl/tpr_pkg.sv */
// Shared constants and carrier types for the two-port parity memory block
package tpr_pkg;

    // Array geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 9;
    localparam int unsigned DEPTH = 256;
    localparam int unsigned PAR_BIT = 8;

    // Register map, byte addresses on the plain register port
    localparam int unsigned REG_ADDR_W = 8;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_ERRCNT = 8'h08;
    localparam logic [7:0] REG_INFO = 8'h0C;

    // Status and mask bit positions
    localparam int unsigned EVT_W = 3;
    localparam int unsigned EVT_WR_PAR = 0;
    localparam int unsigned EVT_RD_PAR = 1;
    localparam int unsigned EVT_COLLIDE = 2;

    // Info register bit positions
    localparam int unsigned INFO_PIPE = 0;
    localparam int unsigned INFO_ODD = 1;
    localparam int unsigned INFO_GEN = 2;

    // Reset values and the error counter top value
    localparam logic [2:0] STATUS_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [7:0] ERRCNT_RST = 8'h00;
    localparam logic [7:0] ERRCNT_MAX = 8'hFF;
    localparam logic [8:0] WORD_RST = 9'h000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // Write port bundle from the fabric
    typedef struct packed {
        logic [ADDR_W-1:0] write_location;
        logic [DATA_W-1:0] write_word;
        logic write_select_n;
        logic write_strobe_n;
    } tpr_wr_port_t;

    // Read port bundle from the fabric
    typedef struct packed {
        logic [ADDR_W-1:0] read_location;
        logic read_select_n;
        logic read_strobe_n;
    } tpr_rd_port_t;

    // Register port request
    typedef struct packed {
        logic [REG_ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tpr_reg_req_t;

endpackage : tpr_pkg

/* rtl/tpr_ram_top.sv */
// Two-port 256 x 9 memory with parity, edge-timed ports and register port
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
module tpr_ram_top #(
    parameter bit READ_PIPELINED = 1'b0
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic write_port_clock_in,
    input wire logic read_port_clock_in,
    input wire tpr_pkg::tpr_wr_port_t wr_port_in,
    input wire tpr_pkg::tpr_rd_port_t rd_port_in,
    input wire logic parity_polarity_sel_in,
    input wire logic parity_generate_en_in,
    output logic [tpr_pkg::DATA_W-1:0] read_word_out,
    output logic read_parity_error_out,
    output logic write_parity_error_out,
    input wire tpr_pkg::tpr_reg_req_t reg_req_in,
    output logic [31:0] reg_rdata_out,
    output logic irq_out
);

    // Storage array, data only, so it carries no reset.
    // Words read before they are first written come back unknown.
    logic [tpr_pkg::DATA_W-1:0] mem_q [tpr_pkg::DEPTH];

    // Previous levels of the two port clocks for edge detection
    logic wclk_prev_q;
    logic rclk_prev_q;
    logic wr_edge;
    logic rd_edge;

    // Write side decode
    logic wr_take;
    logic [tpr_pkg::DATA_W-1:0] wr_store_word;
    logic wr_gen_bit;
    logic wr_chk_err;

    // Read side decode and data path
    // Raw word is the array or bypass output before any register
    logic rd_take;
    logic collide;
    logic [tpr_pkg::DATA_W-1:0] rd_raw_word;
    logic rd_chk_err;

    // Access stage and pipeline stage of the read outputs
    logic [tpr_pkg::DATA_W-1:0] rd_word_q;
    logic rd_err_q;
    logic [tpr_pkg::DATA_W-1:0] pipe_word_q;
    logic pipe_err_q;
    logic wr_err_q;

    // Events, status, mask and counter
    // All of these live in the system clock domain only
    logic [tpr_pkg::EVT_W-1:0] evt;
    logic [tpr_pkg::EVT_W-1:0] status_q;
    logic [tpr_pkg::EVT_W-1:0] status_d;
    logic [tpr_pkg::EVT_W-1:0] mask_q;
    logic [7:0] errcnt_q;
    logic [7:0] errcnt_d;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic rd_err_evt;
    logic wr_err_evt;

    // Register port decodes and the assembled info word
    logic wr_status_hit;
    logic wr_mask_hit;
    logic wr_errcnt_hit;
    logic [2:0] info_bits;

    // Port clocks are sampled levels; a rising edge is a one-cycle strobe here.
    // Both port clocks must stay at or below half the system rate to be seen.
    // Each needs at least one system cycle high and one low between edges.
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wclk_prev_q <= 1'b0;
        end else begin
            wclk_prev_q <= write_port_clock_in;
        end
    end

    // Read clock history kept apart so the two ports stay independent.
    // Cleared in reset, so a clock already high at release counts as an edge.
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rclk_prev_q <= 1'b0;
        end else begin
            rclk_prev_q <= read_port_clock_in;
        end
    end

    // Rising edges, high for exactly one system cycle each
    assign wr_edge = write_port_clock_in & ~wclk_prev_q;
    assign rd_edge = read_port_clock_in & ~rclk_prev_q;

    // Write is taken only with select and strobe both low on a write edge
    // Controls count only in the edge cycle; levels in between are ignored
    assign wr_take = wr_edge & ~wr_port_in.write_select_n
                   & ~wr_port_in.write_strobe_n;

    // Parity unit on the incoming write word
    // Checks the word as it arrives, before a generated bit replaces bit 8
    tpr_parity #(
        .WIDTH(8)
    ) u_wr_parity (
        .data_in(wr_port_in.write_word[7:0]),
        .parity_bit_in(wr_port_in.write_word[tpr_pkg::PAR_BIT]),
        .odd_sel_in(parity_polarity_sel_in),
        .gen_bit_out(wr_gen_bit),
        .error_out(wr_chk_err)
    );

    // With generation on, bit 8 is replaced; otherwise the word is kept whole
    // A generated word is not checked on write, since its own bit 8 is dropped
    always_comb begin
        wr_store_word = wr_port_in.write_word;
        if (parity_generate_en_in) begin
            wr_store_word[tpr_pkg::PAR_BIT] = wr_gen_bit;
        end
    end

    // Array write, independent of any read activity
    // A refused write leaves every stored word untouched
    always_ff @(posedge clk_sys_in) begin
        if (wr_take) begin
            mem_q[wr_port_in.write_location] <= wr_store_word;
        end
    end

    // Write-side error only meaningful while words arrive with their own parity
    // With generation on the flag is held low rather than left undefined
    assign wr_err_evt = wr_take & ~parity_generate_en_in & wr_chk_err;

    // Write error level holds until the next accepted write
    // Held as a level so slow fabric logic can sample it at leisure
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wr_err_q <= 1'b0;
        end else if (wr_take) begin
            wr_err_q <= wr_err_evt;
        end
    end

    // Read is taken only with select and strobe both low on a read edge
    // A refused read leaves the access-stage word and error flag as they were
    assign rd_take = rd_edge & ~rd_port_in.read_select_n
                   & ~rd_port_in.read_strobe_n;

    // Same-location write seen in the same cycle as the read edge
    // Edges one system cycle apart are ordinary traffic, not a collision
    assign collide = rd_take & wr_take
                   & (rd_port_in.read_location == wr_port_in.write_location);

    // Bypass: a write edge with or before the read edge gives the new word.
    // A write edge in a later cycle has not touched the array yet, so the
    // read sees the old word without further logic.
    // The bypassed word carries generated parity when generation is on.
    always_comb begin
        rd_raw_word = mem_q[rd_port_in.read_location];
        if (collide) begin
            rd_raw_word = wr_store_word;
        end
    end

    // Parity check on the word leaving the array
    // Bypass included, so the flag always matches the word returned
    tpr_parity #(
        .WIDTH(8)
    ) u_rd_parity (
        .data_in(rd_raw_word[7:0]),
        .parity_bit_in(rd_raw_word[tpr_pkg::PAR_BIT]),
        .odd_sel_in(parity_polarity_sel_in),
        .gen_bit_out(), // Generated bit not needed on reads
        .error_out(rd_chk_err)
    );

    // Read-side error event for status and counter, one per taken read
    assign rd_err_evt = rd_take & rd_chk_err;

    // Access stage: loads in the cycle of the read edge, so the word shows
    // one system cycle later, well inside the same read clock cycle
    // Costs one system cycle of latency in exchange for glitch-free outputs
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rd_word_q <= tpr_pkg::WORD_RST;
            rd_err_q <= 1'b0;
        end else if (rd_take) begin
            rd_word_q <= rd_raw_word;
            rd_err_q <= rd_chk_err;
        end
    end

    // Output registers advance on every read edge, giving one extra edge
    // Strobe and select do not gate it, just like a plain output register
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            pipe_word_q <= tpr_pkg::WORD_RST;
            pipe_err_q <= 1'b0;
        end else if (rd_edge) begin
            pipe_word_q <= rd_word_q;
            pipe_err_q <= rd_err_q;
        end
    end

    // Mode is a build-time choice; no register can flip it mid-stream
    // Both stages exist in either build; in the plain build the pipeline stage is left unread
    assign read_word_out = READ_PIPELINED ? pipe_word_q : rd_word_q;
    assign read_parity_error_out = READ_PIPELINED ? pipe_err_q : rd_err_q;
    assign write_parity_error_out = wr_err_q;

    // Event vector feeding the sticky status bits
    // One bit per event kind, laid out as the status and mask registers
    always_comb begin
        evt = '0;
        evt[tpr_pkg::EVT_WR_PAR] = wr_err_evt;
        evt[tpr_pkg::EVT_RD_PAR] = rd_err_evt;
        evt[tpr_pkg::EVT_COLLIDE] = collide;
    end

    // Register port write decodes, one per writable offset
    assign wr_status_hit = reg_req_in.wr & (reg_req_in.addr == tpr_pkg::REG_STATUS);
    assign wr_mask_hit = reg_req_in.wr & (reg_req_in.addr == tpr_pkg::REG_MASK);
    assign wr_errcnt_hit = reg_req_in.wr & (reg_req_in.addr == tpr_pkg::REG_ERRCNT);

    // Write-one-to-clear, with a new event winning over the clear.
    // Software thus loses no event landing in the cycle of its clear.
    always_comb begin
        status_d = status_q;
        if (wr_status_hit) begin
            status_d = status_q & ~reg_req_in.wdata[tpr_pkg::EVT_W-1:0];
        end
        status_d = status_d | evt;
    end

    // Sticky status bits
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            status_q <= tpr_pkg::STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // Mask register, software owned
    // A masked event still sets its status bit; only the interrupt is gated
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            mask_q <= tpr_pkg::MASK_RST;
        end else if (wr_mask_hit) begin
            mask_q <= reg_req_in.wdata[tpr_pkg::EVT_W-1:0];
        end
    end

    // Saturating parity error counter; a write to its offset clears it, but a
    // simultaneous error still counts as one so nothing is lost
    always_comb begin
        errcnt_d = errcnt_q;
        if (wr_errcnt_hit) begin
            errcnt_d = tpr_pkg::ERRCNT_RST;
        end
        if ((wr_err_evt || rd_err_evt) && errcnt_d != tpr_pkg::ERRCNT_MAX) begin
            errcnt_d = errcnt_d + 8'h01;
        end
    end

    // Counter register; it sticks at its top value instead of wrapping
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            errcnt_q <= tpr_pkg::ERRCNT_RST;
        end else begin
            errcnt_q <= errcnt_d;
        end
    end

    // Info word: build choice and the two live parity inputs
    always_comb begin
        info_bits = '0;
        info_bits[tpr_pkg::INFO_PIPE] = READ_PIPELINED;
        info_bits[tpr_pkg::INFO_ODD] = parity_polarity_sel_in;
        info_bits[tpr_pkg::INFO_GEN] = parity_generate_en_in;
    end

    // Read mux; unmapped offsets answer zero.
    // Reads have no side effects, so polling status never clears it.
    always_comb begin
        rdata_d = tpr_pkg::RDATA_RST;
        case (reg_req_in.addr)
            tpr_pkg::REG_STATUS: begin
                rdata_d[tpr_pkg::EVT_W-1:0] = status_q;
            end
            tpr_pkg::REG_MASK: begin
                rdata_d[tpr_pkg::EVT_W-1:0] = mask_q;
            end
            tpr_pkg::REG_ERRCNT: begin
                rdata_d[7:0] = errcnt_q;
            end
            tpr_pkg::REG_INFO: begin
                rdata_d[2:0] = info_bits;
            end
            default: begin
                rdata_d = tpr_pkg::RDATA_RST;
            end
        endcase
    end

    // Read data stands only in the cycle after the read strobe
    // Zero otherwise, so a stale value is never mistaken for an answer
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rdata_q <= tpr_pkg::RDATA_RST;
        end else if (reg_req_in.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= tpr_pkg::RDATA_RST;
        end
    end

    // Register port answer straight from its flop
    assign reg_rdata_out = rdata_q;

    // Level interrupt while any unmasked status bit is set
    // Built from two flops, so it drops in the cycle after a clear
    assign irq_out = |(status_q & mask_q);

endmodule : tpr_ram_top

/* testbench/tpr_fabric_model.sv */
// Fabric-side model driving the write and read ports
`timescale 1ns/100ps
module tpr_fabric_model (
    input wire logic clk_sys_in,
    output logic write_port_clock_out,
    output logic read_port_clock_out,
    output tpr_pkg::tpr_wr_port_t wr_port_out,
    output tpr_pkg::tpr_rd_port_t rd_port_out
);
    // Idle: clocks low, both ports deselected
    initial begin
        write_port_clock_out = 1'b0;
        read_port_clock_out = 1'b0;
        wr_port_out = '1;
        rd_port_out = '1;
    end
    // One port clock pulse; controls held through the sampling edge
    task automatic pulse(input logic dw, input tpr_pkg::tpr_wr_port_t w,
        input logic dr, input tpr_pkg::tpr_rd_port_t r);
        @(posedge clk_sys_in);
        write_port_clock_out <= dw;
        read_port_clock_out <= dr;
        wr_port_out <= w;
        rd_port_out <= r;
        @(posedge clk_sys_in);
        write_port_clock_out <= 1'b0;
        read_port_clock_out <= 1'b0;
        // Released address and word show the inverse, select and strobe go high, so stale values cannot pass
        wr_port_out <= {~w.write_location, ~w.write_word, 2'b11};
        rd_port_out <= {~r.read_location, 2'b11};
    endtask : pulse
endmodule : tpr_fabric_model

/* testbench/tpr_ram_checker.sv */
// Port-level assertions for the two-port parity memory
`timescale 1ns/100ps
module tpr_ram_checker #(
    parameter bit READ_PIPELINED = 1'b0
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic write_port_clock_in,
    input wire logic read_port_clock_in,
    input wire tpr_pkg::tpr_wr_port_t wr_port_in,
    input wire tpr_pkg::tpr_rd_port_t rd_port_in,
    input wire logic parity_polarity_sel_in,
    input wire logic parity_generate_en_in,
    input wire logic [tpr_pkg::DATA_W-1:0] read_word_out,
    input wire logic read_parity_error_out,
    input wire logic write_parity_error_out,
    input wire tpr_pkg::tpr_reg_req_t reg_req_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic irq_out
);
    logic wc_q, rc_q, seen_q, wt, rt, rr;
    logic [8:0] mem_q [256];
    logic [8:0] pend_q, st, ex;
    // Port clock edges as the block samples them
    assign wt = write_port_clock_in & ~wc_q & ~wr_port_in.write_select_n
        & ~wr_port_in.write_strobe_n;
    assign rr = read_port_clock_in & ~rc_q;
    assign rt = rr & ~rd_port_in.read_select_n & ~rd_port_in.read_strobe_n;
    // Stored word; generation replaces bit 8
    assign st = parity_generate_en_in ? {parity_polarity_sel_in
        ^ (^wr_port_in.write_word[7:0]), wr_port_in.write_word[7:0]} : wr_port_in.write_word;
    // Same-cycle write wins over the stored word
    assign ex = (wt && wr_port_in.write_location == rd_port_in.read_location) ? st
        : mem_q[rd_port_in.read_location];
    // Edge history, reset like the block so a first-cycle edge is seen alike
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wc_q <= 1'b0;
            rc_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            wc_q <= write_port_clock_in;
            rc_q <= read_port_clock_in;
            seen_q <= seen_q | rt;
        end
    end
    // Shadow array and pipeline stage, no reset like the memory itself
    always_ff @(posedge clk_sys_in) begin
        if (wt) begin
            mem_q[wr_port_in.write_location] <= st;
        end
        if (rt) begin
            pend_q <= ex;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    a_wr_err_value: assert property (
        wt |=> write_parity_error_out == (!$past(parity_generate_en_in)
        && ((^$past(wr_port_in.write_word)) != $past(parity_polarity_sel_in))))
        else $error("write parity flag wrong");
    a_wr_err_hold: assert property (
        !wt |=> $stable(write_parity_error_out))
        else $error("write parity flag moved without a write");
    a_rd_data: assert property (
        (READ_PIPELINED ? rr && seen_q : rt)
        |=> read_word_out == $past(READ_PIPELINED ? pend_q : ex))
        else $error("read word wrong");
    a_rd_hold: assert property (
        !(READ_PIPELINED ? rr : rt) |=> $stable(read_word_out))
        else $error("read word moved without a read");
    a_rd_err: assert property (
        !READ_PIPELINED && rt |=> read_parity_error_out
        == ((^read_word_out) != $past(parity_polarity_sel_in)))
        else $error("read parity flag wrong");
    a_info_bits: assert property (
        reg_req_in.rd && reg_req_in.addr == tpr_pkg::REG_INFO |=> reg_rdata_out[2:0]
        == {$past(parity_generate_en_in), $past(parity_polarity_sel_in), READ_PIPELINED})
        else $error("info bits wrong");
    a_irq_masked: assert property (
        reg_req_in.wr && reg_req_in.addr == tpr_pkg::REG_MASK
        && reg_req_in.wdata[2:0] == 3'h0 |=> !irq_out)
        else $error("interrupt high with all masked");
    a_rdata_idle: assert property (
        !reg_req_in.rd |=> reg_rdata_out == 32'h0000_0000)
        else $error("read data outside a read cycle");
    c_collide: cover property (wt && rt && wr_port_in.write_location == rd_port_in.read_location);
    c_pipe_load: cover property (READ_PIPELINED && rr && seen_q);
    c_irq: cover property (irq_out);
endmodule : tpr_ram_checker

/* testbench/two_port_parity_ram_test.sv */
// Self-checking bench for the two-port parity memory
`timescale 1ns/100ps
module two_port_parity_ram_test;
    logic clk_sys_in, sys_rst_in, write_port_clock_in, read_port_clock_in;
    logic parity_polarity_sel_in, parity_generate_en_in;
    tpr_pkg::tpr_wr_port_t wr_port_in;
    tpr_pkg::tpr_rd_port_t rd_port_in;
    tpr_pkg::tpr_reg_req_t reg_req_in;
    logic [8:0] read_word_out, prw;
    logic read_parity_error_out, write_parity_error_out, irq_out, pre;
    logic [31:0] reg_rdata_out, prd;
    int failures, n_compared;
    tpr_ram_top #(.READ_PIPELINED(1'b0)) i_dut (.*);
    tpr_ram_top #(.READ_PIPELINED(1'b1)) i_dut_pipe (.read_word_out(prw),
        .read_parity_error_out(pre), .write_parity_error_out(), .reg_rdata_out(prd),
        .irq_out(), .*);
    tpr_fabric_model i_fab (.clk_sys_in(clk_sys_in),
        .write_port_clock_out(write_port_clock_in), .read_port_clock_out(read_port_clock_in),
        .wr_port_out(wr_port_in), .rd_port_out(rd_port_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [8:0] d, input logic s, input logic t);
        i_fab.pulse(1'b1, '{a, d, s, t}, 1'b0, '{8'h00, 1'b1, 1'b1});
        #10;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic s, input logic t);
        i_fab.pulse(1'b0, '{8'h00, 9'h000, 1'b1, 1'b1}, 1'b1, '{a, s, t});
        #10;
    endtask : rd
    task automatic rg(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_req_in <= '{a, d, w, ~w};
        @(posedge clk_sys_in);
        reg_req_in <= '0;
        #10;
    endtask : rg
    task automatic pset(input logic p, input logic g);
        @(posedge clk_sys_in);
        parity_polarity_sel_in <= p;
        parity_generate_en_in <= g;
    endtask : pset
    // Two locations at the address ends; pipelined copy lags one read edge
    task automatic t_basic;
        wr(8'h00, 9'h003, 1'b0, 1'b0);
        wr(8'hFF, 9'h180, 1'b0, 1'b0);
        rd(8'h00, 1'b0, 1'b0);
        chk(32'(read_word_out), 32'h003, "low end");
        rd(8'hFF, 1'b0, 1'b0);
        chk(32'(read_word_out), 32'h180, "high end");
        chk(32'(prw), 32'h003, "pipe lag");
        rd(8'h00, 1'b0, 1'b1);
        chk(32'(prw), 32'h180, "pipe advance");
        chk(32'(read_word_out), 32'h180, "strobe high");
    endtask : t_basic
    // Same-cycle write and read, then a write after the read
    task automatic t_collide;
        wr(8'h20, 9'h0AA, 1'b0, 1'b0);
        i_fab.pulse(1'b1, '{8'h20, 9'h055, 1'b0, 1'b0}, 1'b1, '{8'h20, 1'b0, 1'b0});
        #10;
        chk(32'(read_word_out), 32'h055, "collision");
        rd(8'h20, 1'b0, 1'b0);
        wr(8'h20, 9'h0F0, 1'b0, 1'b0);
        chk(32'(read_word_out), 32'h055, "late write");
    endtask : t_collide
    task automatic t_refuse;
        wr(8'h20, 9'h00F, 1'b1, 1'b0);
        wr(8'h20, 9'h00F, 1'b0, 1'b1);
        rd(8'h20, 1'b0, 1'b0);
        chk(32'(read_word_out), 32'h0F0, "write refused");
        rd(8'h00, 1'b1, 1'b0);
        chk(32'(read_word_out), 32'h0F0, "read deselected");
    endtask : t_refuse
    // Both polarities, checked and generated parity
    task automatic t_parity;
        logic e;
        for (int p = 0; p < 2; p++) begin
            pset(p[0], 1'b0);
            e = (^9'h001) != p[0];
            wr(8'h10, 9'h001, 1'b0, 1'b0);
            chk(32'(write_parity_error_out), 32'(e), "write check");
            rd(8'h10, 1'b0, 1'b0);
            chk(32'({read_parity_error_out, read_word_out}), 32'({e, 9'h001}), "rd chk");
            pset(p[0], 1'b1);
            wr(8'h11, 9'h003, 1'b0, 1'b0);
            chk(32'(write_parity_error_out), 32'h0, "write gen");
            rd(8'h11, 1'b0, 1'b0);
            chk(32'({read_parity_error_out, read_word_out}), 32'({2'b00, p[0], 8'h03}), "gen");
            chk(32'({pre, prw}), 32'({e, 9'h001}), "pipe err");
        end
        pset(1'b0, 1'b0);
    endtask : t_parity
    // Status, mask, interrupt, info and an unmapped place
    task automatic t_regs;
        rg(1'b0, tpr_pkg::REG_STATUS, 32'h0);
        chk(reg_rdata_out, 32'h7, "status");
        rg(1'b0, tpr_pkg::REG_ERRCNT, 32'h0);
        chk(reg_rdata_out, 32'h2, "error count");
        rg(1'b1, tpr_pkg::REG_ERRCNT, 32'h0);
        rg(1'b0, tpr_pkg::REG_ERRCNT, 32'h0);
        chk(reg_rdata_out, 32'h0, "count cleared");
        chk(32'(irq_out), 32'h0, "irq masked");
        rg(1'b1, tpr_pkg::REG_MASK, 32'h7);
        chk(32'(irq_out), 32'h1, "irq raised");
        rg(1'b1, tpr_pkg::REG_MASK, 32'h0);
        rg(1'b1, tpr_pkg::REG_MASK, 32'h7);
        rg(1'b1, tpr_pkg::REG_STATUS, 32'h7);
        chk(32'(irq_out), 32'h0, "irq cleared");
        rg(1'b0, tpr_pkg::REG_INFO, 32'h0);
        chk(reg_rdata_out, 32'h0, "info");
        chk(prd, 32'h1, "info pipe");
        rg(1'b0, 8'h10, 32'h0);
        chk(reg_rdata_out, 32'h0, "unmapped");
    endtask : t_regs
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    // Whole run is about 75 cycles; a hang is cut at 1000
    initial begin
        #100_000;
        failures++;
        tally_and_finish;
    end
    initial begin
        sys_rst_in = 1'b1;
        parity_polarity_sel_in = 1'b0;
        parity_generate_en_in = 1'b0;
        reg_req_in = '0;
        repeat (6) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        #10;
        chk(32'({irq_out, read_parity_error_out, write_parity_error_out}), 32'h0, "reset");
        t_basic();
        t_collide();
        t_refuse();
        t_parity();
        t_regs();
        tally_and_finish;
    end
endmodule : two_port_parity_ram_test
bind tpr_ram_top tpr_ram_checker #(.READ_PIPELINED(READ_PIPELINED)) u_chk (.*);
